// *** gpiob_pkg.sv ***
// Purpose: constants and types for the general-purpose pin block
// Assumes: classic wishbone slave, 32-bit data, byte addresses = offset*4
// Notes: printed offsets are register indices
package gpiob_pkg;
   // ****************************************
   // register indices
   // ****************************************
   localparam logic [7:0] IDX_P0_DIR = 8'hb8;
   localparam logic [7:0] IDX_P1_DIR = 8'hc1;
   localparam logic [7:0] IDX_P2_DIR = 8'hc2;
   localparam logic [7:0] IDX_P5_DIR = 8'hc5;
   localparam logic [7:0] IDX_P0_DAT = 8'hd0;
   localparam logic [7:0] IDX_P1_DAT = 8'hd1;
   localparam logic [7:0] IDX_P2_DAT = 8'hd2;
   localparam logic [7:0] IDX_P5_DAT = 8'hd5;
   localparam logic [7:0] IDX_P0_PU = 8'he0;
   localparam logic [7:0] IDX_P1_PU = 8'he1;
   localparam logic [7:0] IDX_P2_PU = 8'he2;
   localparam logic [7:0] IDX_P5_PU = 8'he5;
   localparam logic [7:0] IDX_OD_CTL = 8'he9;
   localparam logic [7:0] IDX_SHARE_CTL = 8'hf0;
   localparam logic [7:0] IDX_SHARE_STAT = 8'hf1;
   // ****************************************
   // implemented bit masks and reset values
   // ****************************************
   localparam logic [7:0] MASK_P0 = 8'h01;
   localparam logic [7:0] MASK_P1_DIR = 8'h0d;
   localparam logic [7:0] MASK_P1_DAT = 8'h0f;
   localparam logic [7:0] MASK_P2 = 8'h3f;
   localparam logic [7:0] MASK_P5 = 8'h10;
   localparam logic [7:0] MASK_OD = 8'h01;
   localparam logic [7:0] RST_VAL = 8'h00;
   localparam logic [7:0] RST_SHARE = 8'h10;
   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_OD_EN = 0;
   localparam int BIT_P10 = 0;
   localparam int BIT_P11 = 1;
   localparam int BIT_P12 = 2;
   localparam int BIT_P13 = 3;
   localparam int BIT_P54 = 4;
   localparam int BIT_EDGE_LO = 3;
   localparam int BIT_EDGE_HI = 4;
   localparam int BIT_IRQ_EN = 0;
   localparam int NUM_PINS = 12;
   // ****************************************
   // high clock source options
   // ****************************************
   typedef enum logic [2:0] {
      GPIOB_CLK_IHRC, GPIOB_CLK_RC, GPIOB_CLK_32K, GPIOB_CLK_4M,
      GPIOB_CLK_12M, GPIOB_CLK_RC_RTC
   } gpiob_clk_t;
   typedef struct packed {
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] p5;
   } gpiob_ports_t;
endpackage

// *** gpiob_top.sv ***
// Purpose: 12-pin general-purpose port block with wishbone registers
// Assumes: inputs synchronous to REF_CLK (50 MHz); RST synchronous high
// Notes: one-cycle ack; register at byte address = index*4
//
// Notes on behaviour
// - twelve pins over ports 0,1,2,5, several shared with special uses
// - direction bit 0 makes pin input, 1 makes it output
// - direction bits are written as a whole byte; no single-bit set or clear
// - port 1 pin 1 is input only; its direction bit has no effect
// - pull-up bit 1 enables pull-up, only while pin is input
// - port 1 pin 1 has no pull-up; its pull-up bit does nothing
// - open-drain control bit 0 set enables open-drain on port 1 pin 0
// - open-drain drives only low; high releases to external pull-up
// - open-drain off returns pin 0 of port 1 to its direction mode
// - with reset-pin option, port 1 pin 1 data always reads 1
// - port 1 pin 1 acts as external reset when option selects reset
// - port 1 pin 3 becomes oscillator input for rc, 32k, 4m, 12m, rtc
// - port 1 pin 2 becomes oscillator output for 32k, 4m, 12m, rtc
// - port 0 pin 0 is ext interrupt; edge field 01 rise 10 fall 11 both
`timescale 1ns/100ps
module gpiob_top #(
   parameter int ADDR_W = 10
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [ADDR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire gpiob_pkg::gpiob_ports_t PIN_I,
   output gpiob_pkg::gpiob_ports_t PIN_O,
   output gpiob_pkg::gpiob_ports_t PIN_OE,
   output gpiob_pkg::gpiob_ports_t PULLUP_EN,
   input wire logic RESET_PIN_OPT,
   input wire gpiob_pkg::gpiob_clk_t HIGH_CLK_OPT,
   input wire logic TIMER_EN,
   input wire logic PWM_OUT_EN,
   input wire logic BUZZER_OUT_EN,
   input wire logic PWM_IN,
   input wire logic BUZZER_IN,
   output logic EXT_RESET_REQ,
   output logic EXT_IRQ_EVENT,
   output logic OSC_IN_SEL,
   output logic OSC_OUT_SEL
);
   initial begin
      if (ADDR_W < 10) $error("ADDR_W must be at least 10");
   end
   // ****************************************
   // bus decode
   // ****************************************
   logic [7:0] idx;
   logic req;
   logic wr;
   logic [7:0] wdat;
   logic ack_ff;
   assign idx = WB_ADR_I[9:2];
   assign req = WB_CYC_I && WB_STB_I && !ack_ff;
   assign wr = req && WB_WE_I && WB_SEL_I[0];
   assign wdat = WB_DAT_I[7:0];
   assign WB_ACK_O = ack_ff;

   function automatic logic [7:0] upd(input logic [7:0] old,
                                      input logic [7:0] msk,
                                      input logic hit);
      upd = hit ? (wdat & msk) : old;
   endfunction

   always_ff @(posedge REF_CLK) begin
      if (RST) ack_ff <= 1'b0;
      else ack_ff <= req;
   end
   // ****************************************
   // registers
   // ****************************************
   gpiob_pkg::gpiob_ports_t dir_ff, dat_ff, pu_ff;
   logic [7:0] od_ff;
   logic [7:0] share_ff;
   // whole-byte writes, only when sel lane 0 is set; no single-bit writes
   always_ff @(posedge REF_CLK) begin
      if (RST) dir_ff <= '0;
      else begin
         dir_ff.p0 <= upd(dir_ff.p0, gpiob_pkg::MASK_P0,
            wr && idx == gpiob_pkg::IDX_P0_DIR);
         dir_ff.p1 <= upd(dir_ff.p1, gpiob_pkg::MASK_P1_DIR,
            wr && idx == gpiob_pkg::IDX_P1_DIR);
         dir_ff.p2 <= upd(dir_ff.p2, gpiob_pkg::MASK_P2,
            wr && idx == gpiob_pkg::IDX_P2_DIR);
         dir_ff.p5 <= upd(dir_ff.p5, gpiob_pkg::MASK_P5,
            wr && idx == gpiob_pkg::IDX_P5_DIR);
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (RST) dat_ff <= '0;
      else begin
         dat_ff.p0 <= upd(dat_ff.p0, gpiob_pkg::MASK_P0,
            wr && idx == gpiob_pkg::IDX_P0_DAT);
         dat_ff.p1 <= upd(dat_ff.p1, gpiob_pkg::MASK_P1_DIR,
            wr && idx == gpiob_pkg::IDX_P1_DAT);
         dat_ff.p2 <= upd(dat_ff.p2, gpiob_pkg::MASK_P2,
            wr && idx == gpiob_pkg::IDX_P2_DAT);
         dat_ff.p5 <= upd(dat_ff.p5, gpiob_pkg::MASK_P5,
            wr && idx == gpiob_pkg::IDX_P5_DAT);
      end
   end
   always_ff @(posedge REF_CLK) begin
      if (RST) pu_ff <= '0;
      else begin
         pu_ff.p0 <= upd(pu_ff.p0, gpiob_pkg::MASK_P0,
            wr && idx == gpiob_pkg::IDX_P0_PU);
         pu_ff.p1 <= upd(pu_ff.p1, gpiob_pkg::MASK_P1_DIR,
            wr && idx == gpiob_pkg::IDX_P1_PU);
         pu_ff.p2 <= upd(pu_ff.p2, gpiob_pkg::MASK_P2,
            wr && idx == gpiob_pkg::IDX_P2_PU);
         pu_ff.p5 <= upd(pu_ff.p5, gpiob_pkg::MASK_P5,
            wr && idx == gpiob_pkg::IDX_P5_PU);
      end
   end
   // open-drain control kept apart from direction so mode returns
   always_ff @(posedge REF_CLK) begin
      if (RST) od_ff <= gpiob_pkg::RST_VAL;
      else od_ff <= upd(od_ff, gpiob_pkg::MASK_OD,
         wr && idx == gpiob_pkg::IDX_OD_CTL);
   end
   // bit 0 irq enable, bits 4:3 edge select
   always_ff @(posedge REF_CLK) begin
      if (RST) share_ff <= gpiob_pkg::RST_SHARE;
      else share_ff <= upd(share_ff, 8'h19,
         wr && idx == gpiob_pkg::IDX_SHARE_CTL);
   end
   // ****************************************
   // special function selection
   // ****************************************
   logic osc_in;
   logic osc_out;
   logic od_on;
   logic irq_en;
   logic [1:0] edge_sel;
   logic pwm_sel;
   logic bz_sel;
   always_comb begin
      case (HIGH_CLK_OPT)
         gpiob_pkg::GPIOB_CLK_RC: begin
            osc_in = 1'b1;
            osc_out = 1'b0;
         end
         gpiob_pkg::GPIOB_CLK_32K, gpiob_pkg::GPIOB_CLK_4M,
         gpiob_pkg::GPIOB_CLK_12M, gpiob_pkg::GPIOB_CLK_RC_RTC: begin
            osc_in = 1'b1;
            osc_out = 1'b1;
         end
         default: begin
            osc_in = 1'b0;
            osc_out = 1'b0;
         end
      endcase
   end
   assign od_on = od_ff[gpiob_pkg::BIT_OD_EN];
   assign irq_en = share_ff[gpiob_pkg::BIT_IRQ_EN];
   assign edge_sel = share_ff[gpiob_pkg::BIT_EDGE_HI:
                              gpiob_pkg::BIT_EDGE_LO];
   assign pwm_sel = TIMER_EN && PWM_OUT_EN;
   assign bz_sel = TIMER_EN && BUZZER_OUT_EN && !PWM_OUT_EN;
   assign OSC_IN_SEL = osc_in;
   assign OSC_OUT_SEL = osc_out;
   // ****************************************
   // pin drive
   // ****************************************
   always_comb begin
      PIN_O = dat_ff;
      PIN_OE = dir_ff;
      PIN_OE.p1[gpiob_pkg::BIT_P11] = 1'b0;
      if (od_on) begin
         PIN_O.p1[gpiob_pkg::BIT_P10] = 1'b0;
         PIN_OE.p1[gpiob_pkg::BIT_P10] =
            dir_ff.p1[gpiob_pkg::BIT_P10] &&
            !dat_ff.p1[gpiob_pkg::BIT_P10];
      end
      if (osc_in) PIN_OE.p1[gpiob_pkg::BIT_P13] = 1'b0;
      if (osc_out) PIN_OE.p1[gpiob_pkg::BIT_P12] = 1'b0;
      if (pwm_sel || bz_sel) begin
         PIN_OE.p5[gpiob_pkg::BIT_P54] = 1'b1;
         PIN_O.p5[gpiob_pkg::BIT_P54] = pwm_sel ? PWM_IN : BUZZER_IN;
      end
      if (irq_en) PIN_OE.p0[0] = 1'b0;
      PULLUP_EN = pu_ff & ~PIN_OE;
      PULLUP_EN.p1[gpiob_pkg::BIT_P11] = 1'b0;
      if (osc_in) PULLUP_EN.p1[gpiob_pkg::BIT_P13] = 1'b0;
      if (osc_out) PULLUP_EN.p1[gpiob_pkg::BIT_P12] = 1'b0;
   end
   // ****************************************
   // external reset and interrupt edge
   // ****************************************
   logic p00_ff;
   logic rise;
   logic fall;
   always_ff @(posedge REF_CLK) begin
      if (RST) p00_ff <= 1'b0;
      else p00_ff <= PIN_I.p0[0];
   end
   assign rise = PIN_I.p0[0] && !p00_ff;
   assign fall = !PIN_I.p0[0] && p00_ff;
   always_ff @(posedge REF_CLK) begin
      if (RST) EXT_IRQ_EVENT <= 1'b0;
      else EXT_IRQ_EVENT <= (edge_sel[0] && rise) ||
                            (edge_sel[1] && fall);
   end
   // reset request when pin low and option selects reset
   always_ff @(posedge REF_CLK) begin
      if (RST) EXT_RESET_REQ <= 1'b0;
      else EXT_RESET_REQ <= RESET_PIN_OPT &&
                            !PIN_I.p1[gpiob_pkg::BIT_P11];
   end
   // ****************************************
   // read path
   // ****************************************
   gpiob_pkg::gpiob_ports_t rd_pins;
   logic [7:0] rdat;
   always_comb begin
      rd_pins = (PIN_I & ~PIN_OE) | (dat_ff & PIN_OE);
      if (RESET_PIN_OPT) rd_pins.p1[gpiob_pkg::BIT_P11] = 1'b1;
      case (idx)
         gpiob_pkg::IDX_P0_DIR: rdat = dir_ff.p0;
         gpiob_pkg::IDX_P1_DIR: rdat = dir_ff.p1;
         gpiob_pkg::IDX_P2_DIR: rdat = dir_ff.p2;
         gpiob_pkg::IDX_P5_DIR: rdat = dir_ff.p5;
         gpiob_pkg::IDX_P0_DAT: rdat = rd_pins.p0 & gpiob_pkg::MASK_P0;
         gpiob_pkg::IDX_P1_DAT:
            rdat = rd_pins.p1 & gpiob_pkg::MASK_P1_DAT;
         gpiob_pkg::IDX_P2_DAT: rdat = rd_pins.p2 & gpiob_pkg::MASK_P2;
         gpiob_pkg::IDX_P5_DAT: rdat = rd_pins.p5 & gpiob_pkg::MASK_P5;
         gpiob_pkg::IDX_SHARE_CTL: rdat = share_ff;
         gpiob_pkg::IDX_SHARE_STAT:
            rdat = {4'h0, bz_sel, pwm_sel, osc_out, osc_in};
         default: rdat = 8'h00;
      endcase
   end
   always_ff @(posedge REF_CLK) begin
      if (RST) WB_DAT_O <= 32'h0;
      else if (req && !WB_WE_I) WB_DAT_O <= {24'h0, rdat};
   end
   // ****************************************
   // checks
   // ****************************************
   sequence od_high_s;
      od_on && PIN_O.p1[gpiob_pkg::BIT_P10] == 1'b0;
   endsequence
   od_drive_low_a: assert property (@(posedge REF_CLK) disable iff (RST)
      od_on |-> od_high_s) else $error("open-drain drove high");
   in_only_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !PIN_OE.p1[gpiob_pkg::BIT_P11]) else $error("p11 driven");
   pu_input_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (PULLUP_EN & PIN_OE) == '0) else $error("pull-up on output");
   p11_pu_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !PULLUP_EN.p1[gpiob_pkg::BIT_P11]) else $error("p11 pull-up");
   rst_read_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (req && !WB_WE_I && idx == gpiob_pkg::IDX_P1_DAT && RESET_PIN_OPT)
      |=> WB_DAT_O[1]) else $error("p11 not one");
   dir_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr && idx == gpiob_pkg::IDX_P2_DIR)
      |=> dir_ff.p2 == ($past(wdat) & gpiob_pkg::MASK_P2))
      else $error("direction not stored");
   osc_pin_a: assert property (@(posedge REF_CLK) disable iff (RST)
      osc_out |-> osc_in && !PIN_OE.p1[gpiob_pkg::BIT_P12])
      else $error("osc output pin driven");
   pwm_pin_a: assert property (@(posedge REF_CLK) disable iff (RST)
      pwm_sel |-> PIN_OE.p5[gpiob_pkg::BIT_P54] &&
      PIN_O.p5[gpiob_pkg::BIT_P54] == PWM_IN)
      else $error("pwm not routed");
   od_return_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !od_on |-> PIN_OE.p1[0] == dir_ff.p1[0])
      else $error("p10 mode lost");
   ack_one_a: assert property (@(posedge REF_CLK) disable iff (RST)
      WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   // ****************************************
   // further checks
   // ****************************************
   sequence bus_read_s;
      req && !WB_WE_I;
   endsequence
   sequence ack_given_s;
      WB_ACK_O;
   endsequence
   ack_after_req_a: assert property (@(posedge REF_CLK) disable iff (RST)
      req |=> ack_given_s) else $error("no ack after request");
   rd_upper_a: assert property (@(posedge REF_CLK) disable iff (RST)
      bus_read_s |=> WB_DAT_O[31:8] == 24'h0)
      else $error("read upper bits set");
   p1_dir_bit_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !dir_ff.p1[gpiob_pkg::BIT_P11]) else $error("p11 dir stored");
   osc_in_pin_a: assert property (@(posedge REF_CLK) disable iff (RST)
      osc_in |-> !PIN_OE.p1[gpiob_pkg::BIT_P13])
      else $error("osc input pin driven");
   osc_in_pu_a: assert property (@(posedge REF_CLK) disable iff (RST)
      osc_in |-> !PULLUP_EN.p1[gpiob_pkg::BIT_P13])
      else $error("osc input pin pulled");
   osc_out_pu_a: assert property (@(posedge REF_CLK) disable iff (RST)
      osc_out |-> !PULLUP_EN.p1[gpiob_pkg::BIT_P12])
      else $error("osc output pin pulled");
   od_release_a: assert property (@(posedge REF_CLK) disable iff (RST)
      od_on && dat_ff.p1[gpiob_pkg::BIT_P10] |->
      !PIN_OE.p1[gpiob_pkg::BIT_P10]) else $error("od high driven");
   bz_pin_a: assert property (@(posedge REF_CLK) disable iff (RST)
      bz_sel |-> PIN_OE.p5[gpiob_pkg::BIT_P54] &&
      PIN_O.p5[gpiob_pkg::BIT_P54] == BUZZER_IN)
      else $error("buzzer not routed");
   irq_input_a: assert property (@(posedge REF_CLK) disable iff (RST)
      irq_en |-> !PIN_OE.p0[0]) else $error("irq pin driven");
   ext_rst_a: assert property (@(posedge REF_CLK) disable iff (RST)
      RESET_PIN_OPT && !PIN_I.p1[gpiob_pkg::BIT_P11] |=> EXT_RESET_REQ)
      else $error("no reset request");
   no_ext_rst_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !RESET_PIN_OPT |=> !EXT_RESET_REQ) else $error("stray reset");
   rise_ev_a: assert property (@(posedge REF_CLK) disable iff (RST)
      edge_sel == 2'b01 && rise |=> EXT_IRQ_EVENT)
      else $error("rising edge missed");
   edge_none_a: assert property (@(posedge REF_CLK) disable iff (RST)
      edge_sel == 2'b00 |=> !EXT_IRQ_EVENT) else $error("edge 00 event");
   out_mode_a: assert property (@(posedge REF_CLK) disable iff (RST)
      PIN_OE.p2 == dir_ff.p2) else $error("p2 mode wrong");
   pu_p2_a: assert property (@(posedge REF_CLK) disable iff (RST)
      PULLUP_EN.p2 == (pu_ff.p2 & ~dir_ff.p2))
      else $error("p2 pull-up wrong");
   od_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr && idx == gpiob_pkg::IDX_OD_CTL)
      |=> od_ff == ($past(wdat) & gpiob_pkg::MASK_OD))
      else $error("open-drain not stored");
   dat_write_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr && idx == gpiob_pkg::IDX_P0_DAT)
      |=> dat_ff.p0 == ($past(wdat) & gpiob_pkg::MASK_P0))
      else $error("data not stored");
   dir_p1_a: assert property (@(posedge REF_CLK) disable iff (RST)
      (wr && idx == gpiob_pkg::IDX_P1_DIR)
      |=> dir_ff.p1 == ($past(wdat) & gpiob_pkg::MASK_P1_DIR))
      else $error("p1 direction not stored");
endmodule // gpiob_top

// *** gpiob_board.sv ***
// Purpose: board model around the pins of the port block
// Assumes: the bench chooses which pins the board drives and to what level
// Notes: a line nobody drives and nothing pulls up toggles every cycle
`timescale 1ns/100ps
module gpiob_board (
   input wire logic clk,
   input wire gpiob_pkg::gpiob_ports_t pin_o,
   input wire gpiob_pkg::gpiob_ports_t pin_oe,
   input wire gpiob_pkg::gpiob_ports_t pullup_en,
   input wire gpiob_pkg::gpiob_ports_t ext_en,
   input wire gpiob_pkg::gpiob_ports_t ext_val,
   output gpiob_pkg::gpiob_ports_t pin_i
);
   // ********************************
   // line levels
   // ********************************
   logic [31:0] flt_ff = 32'h5555_5555;
   logic [31:0] pu;
   always_ff @(posedge clk) begin
      flt_ff <= ~flt_ff;
   end
   // external resistor on the open-drain pin
   always_comb begin
      pu = pullup_en;
      pu[16] = 1'b1;
   end
   // the block wins over the board; released lines go to their pull-up
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pu | flt_ff));
endmodule // gpiob_board

// *** test_gpiob_top.sv ***
// Purpose: register-level test of the general-purpose pin block
// Assumes: one-cycle wishbone answer, register at byte address index*4
// Notes: expected values come from the register table and pin rules
`timescale 1ns/100ps
module test_gpiob_top;
   // ********************************
   // signals
   // ********************************
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   gpiob_pkg::gpiob_ports_t pin_i, pin_o, pin_oe, pull_en;
   gpiob_pkg::gpiob_ports_t ext_en = 32'hffff_ffff;
   gpiob_pkg::gpiob_ports_t ext_val = 32'h0;
   logic rst_opt = 1'b0;
   logic tmr = 1'b0;
   logic pwm_en = 1'b0;
   logic bz_en = 1'b0;
   logic pwm_in = 1'b0;
   logic bz_in = 1'b0;
   gpiob_pkg::gpiob_clk_t hclk = gpiob_pkg::GPIOB_CLK_IHRC;
   logic ext_rst, irq_ev, osc_in, osc_out;
   logic [7:0] rd;
   logic [7:0] regs [14] = '{8'hb8, 8'hc1, 8'hc2, 8'hc5, 8'hd0, 8'hd1,
      8'hd2, 8'hd5, 8'he0, 8'he1, 8'he2, 8'he5, 8'he9, 8'h10};
   logic [7:0] dirs [4] = '{8'hb8, 8'hc1, 8'hc2, 8'hc5};
   logic [7:0] msks [4] = '{8'h01, 8'h0d, 8'h3f, 8'h10};
   logic [15:0] mux_tab = 16'hda34;
   int bad_count = 0;
   int n_checks = 0;
   int evs;
   always #10 clk = ~clk;
   gpiob_top dut (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .PIN_I(pin_i), .PIN_O(pin_o),
      .PIN_OE(pin_oe), .PULLUP_EN(pull_en), .RESET_PIN_OPT(rst_opt),
      .HIGH_CLK_OPT(hclk), .TIMER_EN(tmr), .PWM_OUT_EN(pwm_en),
      .BUZZER_OUT_EN(bz_en), .PWM_IN(pwm_in), .BUZZER_IN(bz_in),
      .EXT_RESET_REQ(ext_rst), .EXT_IRQ_EVENT(irq_ev),
      .OSC_IN_SEL(osc_in), .OSC_OUT_SEL(osc_out));
   gpiob_board board (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pullup_en(pull_en), .ext_en(ext_en), .ext_val(ext_val),
      .pin_i(pin_i));
   // ********************************
   // tasks
   // ********************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one classic cycle; holds the request until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wdat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         bad_count++;
         print_verdict();
      end
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // ********************************
   // scenarios
   // ********************************
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[k]) begin
         wb(1'b0, regs[k], 8'h00);
         chk(rd, 8'h00);
      end
      wb(1'b0, 8'hf0, 8'h00);
      chk(rd, 8'h10);
      foreach (dirs[k]) begin
         wb(1'b1, dirs[k], 8'hff);
         wb(1'b0, dirs[k], 8'h00);
         chk(rd, msks[k]);
      end
      @(negedge clk);
      chk(pin_oe & 32'h010f3f10, 32'h010d3f10);
      wb(1'b1, 8'hd2, 8'hff);
      @(negedge clk);
      chk(pin_o.p2[5:0], 6'h3f);
      ext_val.p2 <= 8'h20;
      wb(1'b1, 8'hc2, 8'h0f);
      @(negedge clk);
      chk(pin_oe.p2[5:0], 6'h0f);
      wb(1'b0, 8'hd2, 8'h00);
      chk(rd, 8'h2f);
      wb(1'b1, 8'hc1, 8'h00);
      wb(1'b1, 8'he1, 8'hff);
      wb(1'b1, 8'he2, 8'hff);
      @(negedge clk);
      chk(pull_en.p1[3:0], 4'hd);
      chk(pull_en.p2[5:0], 6'h30);
      wb(1'b0, 8'he2, 8'h00);
      chk(rd, 8'h00);
      ext_en.p1[0] <= 1'b0;
      wb(1'b1, 8'hc1, 8'h01);
      wb(1'b1, 8'hd1, 8'h00);
      wb(1'b1, 8'he9, 8'h01);
      @(negedge clk);
      chk({pin_oe.p1[0], pin_o.p1[0]}, 2'b10);
      wb(1'b1, 8'hd1, 8'h01);
      @(negedge clk);
      chk(pin_oe.p1[0], 1'b0);
      chk(pin_i.p1[0], 1'b1);
      wb(1'b1, 8'he9, 8'h00);
      @(negedge clk);
      chk({pin_oe.p1[0], pin_o.p1[0]}, 2'b11);
      rst_opt <= 1'b1;
      repeat (4) @(posedge clk);
      chk(ext_rst, 1'b1);
      wb(1'b0, 8'hd1, 8'h00);
      chk(rd[1], 1'b1);
      rst_opt <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         hclk <= gpiob_pkg::gpiob_clk_t'(k);
         @(negedge clk);
         chk(osc_in, k != 0);
         chk(osc_out, k >= 2);
      end
      tmr <= 1'b1;
      bz_en <= 1'b1;
      for (int k = 3; k >= 0; k--) begin
         @(posedge clk);
         {pwm_en, pwm_in, bz_in} <= mux_tab[4*k+1 +: 3];
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk(pin_o.p5[4], mux_tab[4*k]);
      end
      for (int e = 0; e < 4; e++) begin
         wb(1'b1, 8'hf0, 8'(e * 8 + 1));
         evs = 0;
         ext_val.p0[0] <= 1'b1;
         repeat (8) @(posedge clk) evs += irq_ev;
         ext_val.p0[0] <= 1'b0;
         repeat (8) @(posedge clk) evs += irq_ev;
         chk(evs, (e == 3) ? 2 : (e != 0));
      end
      print_verdict();
   end
endmodule // test_gpiob_top
